// File: design/usart_clk_frame.sv
// Serial clock generation and frame handling with an APB register slave.
// Assumes one clock, inputs synchronous to ref_clk except transfer_clock_in.
//
// How it works
// R01: Four clock modes; sync select picks synchronous
// R02: Clock pin direction picks master or slave
// R03: Clock pin idle in asynchronous modes
// R04: Down-counter reloads at zero or low write
// R05: Tick each zero: rate clock over divisor+1
// R06: Transmit divides ticks by 16, 8, 2
// R07: Receiver runs on ticks, 16/8/2 states
// R08: Divisor twelve bits from high and low
// R09: Double speed ignored in synchronous modes
// R10: Double speed halves divider and samples
// R11: Slave clock synchronised then edge detected
// R12: Peer keeps slave clock below quarter rate
// R13: Sample on edge opposite to change edge
// R14: Polarity clear: change rising, sample falling
// R15: Five to nine bits, parity, stops
// R16: Start, data LSB first, parity, stops
// R17: Back-to-back frames or idle high
// R18: Frame settings shared by both directions
// R19: Only first stop bit checked for error
// R20: Parity is data XOR, inverted for odd
// R21: Software idles link before changing settings
// R22: Size seven means nine bits, separate bit
// R23: Parity only when upper mode bit set
// R24: Size 0-3 is 5-8; parity 2 even, 3 odd
// R25: Master drives transmit bit clock on pin
`default_nettype none
`include "usart_clk_map.svh"
module usart_clk_frame (
  input  wire logic                    ref_clk,
  input  wire logic                    arst_n,
  input  wire logic                    clk_en,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [11:0]             paddr,
  input  wire logic [31:0]             pwdata,
  output logic      [31:0]             prdata,
  output logic                         pready,
  output logic                         pslverr,
  input  wire logic                    serial_in_pin,
  output logic                         serial_out_pin,
  input  wire logic                    transfer_clock_in,
  output logic                         transfer_clock_out,
  output logic                         transfer_clock_oe,
  output usart_clk_pkg::clk_mode_t     clock_mode
);
  import usart_clk_pkg::*;

  // Software settings, buffers and status flags
  logic        double_speed;        // Async rate doubling
  logic        tx_complete_flag;    // Frame out, nothing queued
  logic        rx_complete_flag;    // Unread character held
  logic        tx_bit8;             // Ninth transmit bit
  logic        tx_enable;           // Transmitter on
  logic        rx_enable;           // Receiver on
  logic [7:0]  ctrl_c;              // Mode, format, polarity
  logic        char_size_hi;        // Upper char_size bit
  logic [11:0] baud_divisor;        // Divider value
  logic [8:0]  tx_buf;              // Pending character
  logic        tx_buf_full;         // Pending character valid
  logic [8:0]  rx_buf;              // Received character
  logic        frame_error_flag;    // First stop bit was low
  logic        parity_error;        // Parity mismatch

  // Decoded configuration
  wire         sync_mode_select    = ctrl_c[`C_SYNC_MODE];
  wire         clock_pin_direction = ctrl_c[`C_CLOCK_DIR];
  wire         sync_clock_polarity = ctrl_c[`C_CLOCK_POLARITY];
  wire         stop_bits_select    = ctrl_c[`C_STOP_BITS];
  wire [1:0]   parity_mode         = ctrl_c[`C_PARITY_MODE+:2];
  wire [2:0]   char_size           = {char_size_hi, ctrl_c[`C_CHAR_SIZE_LO+:2]};
  // Mode selection: double speed only counts when asynchronous
  wire         eff_double          = double_speed & ~sync_mode_select;  // R09
  wire         is_master           = sync_mode_select & clock_pin_direction;  // R02
  wire         is_slave            = sync_mode_select & ~clock_pin_direction;  // R02
  wire clk_mode_t next_mode        = sync_mode_select ? (clock_pin_direction ? MODE_SYNC_MASTER
                                     : MODE_SYNC_SLAVE) : (eff_double ? MODE_ASYNC_DOUBLE
                                     : MODE_ASYNC_NORMAL);  // R01
  // Samples per bit by mode
  wire [4:0]   bit_states          = sync_mode_select ? `STATES_SYNC
                                     : (eff_double ? `STATES_DOUBLE : `STATES_NORMAL);      // R07 R10
  // Data bits per character: 0-3 give 5-8, 7 gives nine
  wire [3:0]   nbits               = (char_size == `CHAR_SIZE_NINE) ? 4'h9
                                     : (4'h5 + {2'h0, char_size[1:0]});  // R22 R24
  wire         parity_on           = parity_mode[1];  // R23
  wire         parity_odd          = (parity_mode == `PARITY_ODD);  // R24

  // APB decode
  wire         apb_setup_wr        = psel & ~penable & pwrite;
  wire         apb_wr              = psel & penable & pwrite & pready;
  wire         apb_rd              = psel & ~penable & ~pwrite;
  wire         hit_a               = (paddr == `OFS_CTRL_A);
  wire         hit_b               = (paddr == `OFS_CTRL_B);
  wire         hit_c               = (paddr == `OFS_CTRL_C);
  wire         hit_lo              = (paddr == `OFS_DIV_LOW);
  wire         hit_hi              = (paddr == `OFS_DIV_HIGH);
  wire         hit_data            = (paddr == `OFS_DATA);
  wire         hit_stat            = (paddr == `OFS_STATUS);
  wire         mapped              = hit_a | hit_b | hit_c | hit_lo | hit_hi | hit_data | hit_stat;
  wire         wr_lo               = apb_wr & hit_lo;
  wire         wr_data             = apb_wr & hit_data;
  wire         rd_data             = apb_rd & hit_data;

  // Baud down-counter
  logic [11:0] baud_count;          // Counts toward zero
  wire         baud_tick           = (baud_count == 12'h000);  // R05

  // Slave clock synchroniser and edge detector
  logic        xck_meta;            // First stage, read only by second
  logic        xck_sync;            // Second stage
  logic        xck_prev;            // Edge detector history
  wire         xck_rise            = xck_sync & ~xck_prev;  // R11
  wire         xck_fall            = ~xck_sync & xck_prev;  // R11

  // Transmit bit clock divider
  logic [3:0]  tx_div;              // Tick count within one bit
  logic        master_clk;          // Generated transfer clock level
  wire         tx_div_end          = baud_tick & (tx_div == 4'(bit_states - 5'd1));  // R06
  // Master clock edges: each tick toggles, period is two ticks
  wire         m_rise              = is_master & baud_tick & ~master_clk;  // R25
  wire         m_fall              = is_master & baud_tick & master_clk;
  wire         sync_rise           = is_slave ? xck_rise : m_rise;
  wire         sync_fall           = is_slave ? xck_fall : m_fall;
  // Change edge and sample edge swap with polarity
  wire         sync_change         = sync_clock_polarity ? sync_fall : sync_rise;  // R14
  wire         sync_sample         = sync_clock_polarity ? sync_rise : sync_fall;  // R13 R14
  wire         tx_step             = sync_mode_select ? sync_change : tx_div_end;  // R06

  // Transmitter state
  phase_t      tx_ph;               // Current frame part
  logic [8:0]  tx_shift;            // Bits still to send
  logic [3:0]  tx_cnt;              // Data bits sent
  logic        tx_par;              // Running parity
  wire         tx_last             = (tx_cnt == nbits - 4'h1);
  wire         tx_load             = tx_buf_full & tx_enable;
  phase_t      next_tx_ph;
  always_comb begin
    // Next transmit phase at each bit boundary
    case (tx_ph)
      PH_IDLE:   next_tx_ph = tx_load ? PH_START : PH_IDLE;
      PH_START:  next_tx_ph = PH_DATA;  // R16
      PH_DATA:   next_tx_ph = !tx_last ? PH_DATA : (parity_on ? PH_PARITY : PH_STOP1);       // R23
      PH_PARITY: next_tx_ph = PH_STOP1;
      PH_STOP1:  next_tx_ph = stop_bits_select ? PH_STOP2 : (tx_load ? PH_START : PH_IDLE); // R17
      PH_STOP2:  next_tx_ph = tx_load ? PH_START : PH_IDLE;  // R17
      default:   next_tx_ph = PH_IDLE;
    endcase
  end
  wire         tx_start            = tx_step & (next_tx_ph == PH_START);
  wire         tx_done             = tx_step & (next_tx_ph == PH_IDLE) & (tx_ph != PH_IDLE);

  // Receiver state
  phase_t      rx_ph;               // Current frame part
  logic [3:0]  rx_sub;              // Sample slot within bit
  logic [3:0]  rx_cnt;              // Data bits taken
  logic [8:0]  rx_shift;            // Assembled character
  logic        rx_par;              // Running parity
  wire [3:0]   rx_mid              = 4'(bit_states[4:1]);
  wire         rx_async_smp        = baud_tick & (rx_sub == 4'(rx_mid - 4'h1));  // R07
  wire         rx_smp              = sync_mode_select ? sync_sample : rx_async_smp;  // R13
  wire         rx_last             = (rx_cnt == nbits - 4'h1);

  // Register writes and flags
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      double_speed     <= 1'b0;
      tx_bit8          <= 1'b0;
      tx_enable        <= 1'b0;
      rx_enable        <= 1'b0;
      ctrl_c           <= `RST_CTRL_C;
      char_size_hi     <= 1'b0;
      baud_divisor     <= `RST_DIVISOR;
      tx_buf           <= 9'h000;
      tx_buf_full      <= 1'b0;
      tx_complete_flag <= 1'b0;
    end else if (clk_en) begin
      // Control writes
      if (apb_wr & hit_a) begin
        double_speed <= pwdata[`A_DOUBLE_SPEED];
      end
      if (apb_wr & hit_b) begin
        tx_bit8      <= pwdata[`B_TX_BIT8];
        tx_enable    <= pwdata[`B_TX_ENABLE];
        rx_enable    <= pwdata[`B_RX_ENABLE];
        char_size_hi <= pwdata[`B_CHAR_SIZE_HI];
      end
      if (apb_wr & hit_c) begin
        ctrl_c <= pwdata[7:0];  // R18
      end
      // Divisor halves
      if (wr_lo) begin
        baud_divisor[7:0] <= pwdata[7:0];  // R08
      end
      if (apb_wr & hit_hi) begin
        baud_divisor[11:8] <= pwdata[3:0];  // R08
      end
      // Transmit buffer: ninth bit from control B
      if (wr_data) begin
        tx_buf      <= {tx_bit8, pwdata[7:0]};  // R22
        tx_buf_full <= 1'b1;
      end else if (tx_start) begin
        tx_buf_full <= 1'b0;
      end
      // Completion flag: set wins over write-one clear
      if (tx_done & ~tx_buf_full) begin
        tx_complete_flag <= 1'b1;
      end else if (apb_wr & hit_a & pwdata[`A_TX_COMPLETE]) begin
        tx_complete_flag <= 1'b0;
      end
    end
  end

  // Baud generator: reload at zero or on divisor low write
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      baud_count <= `RST_DIVISOR;
    end else if (clk_en) begin
      if (wr_lo) begin
        baud_count <= {baud_divisor[11:8], pwdata[7:0]};  // R04
      end else if (baud_tick) begin
        baud_count <= baud_divisor;  // R04
      end else begin
        baud_count <= baud_count - 12'h001;  // R04
      end
    end
  end

  // Slave clock synchroniser, used only in slave mode
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      xck_meta <= 1'b0;
      xck_sync <= 1'b0;
      xck_prev <= 1'b0;
    end else if (clk_en) begin
      xck_meta <= transfer_clock_in;  // R11
      xck_sync <= xck_meta;
      xck_prev <= xck_sync;
    end
  end

  // Transmit divider and master clock
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_div     <= 4'h0;
      master_clk <= 1'b0;
    end else if (clk_en) begin
      if (baud_tick) begin
        tx_div <= tx_div_end ? 4'h0 : tx_div + 4'h1;  // R06
      end
      if (!is_master) begin
        master_clk <= sync_clock_polarity;
      end else if (baud_tick) begin
        master_clk <= ~master_clk;  // R25
      end
    end
  end

  // Transmit shifter
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_ph          <= PH_IDLE;
      tx_shift       <= 9'h000;
      tx_cnt         <= 4'h0;
      tx_par         <= 1'b0;
      serial_out_pin <= 1'b1;
    end else if (clk_en && tx_step) begin
      tx_ph <= next_tx_ph;
      case (next_tx_ph)
        PH_START: begin
          tx_shift       <= tx_buf;
          tx_cnt         <= 4'h0;
          tx_par         <= 1'b0;
          serial_out_pin <= 1'b0;  // R16
        end
        PH_DATA: begin
          serial_out_pin <= tx_shift[0];  // R16
          tx_par         <= tx_par ^ tx_shift[0];  // R20
          tx_shift       <= {1'b0, tx_shift[8:1]};
          tx_cnt         <= (tx_ph == PH_DATA) ? tx_cnt + 4'h1 : 4'h0;
        end
        PH_PARITY: begin
          serial_out_pin <= tx_par ^ parity_odd;  // R20
        end
        default: begin
          serial_out_pin <= 1'b1;  // R17
        end
      endcase
    end
  end

  // Receiver: start detect, mid-bit or clock-edge sampling
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_ph            <= PH_IDLE;
      rx_sub           <= 4'h0;
      rx_cnt           <= 4'h0;
      rx_shift         <= 9'h000;
      rx_par           <= 1'b0;
      rx_buf           <= 9'h000;
      rx_complete_flag <= 1'b0;
      frame_error_flag <= 1'b0;
      parity_error     <= 1'b0;
    end else if (clk_en) begin
      if (!sync_mode_select && baud_tick) begin
        rx_sub <= (rx_ph == PH_IDLE || rx_sub == 4'(bit_states - 5'd1)) ? 4'h0 : rx_sub + 4'h1;
      end
      if (rx_ph == PH_IDLE) begin
        if (rx_enable && !serial_in_pin && (sync_mode_select ? rx_smp : baud_tick)) begin
          rx_ph  <= sync_mode_select ? PH_DATA : PH_START;
          rx_cnt <= 4'h0;
          rx_par <= 1'b0;
        end
      end else if (rx_smp) begin
        case (rx_ph)
          PH_START: begin
            rx_ph <= serial_in_pin ? PH_IDLE : PH_DATA;  // R16
          end
          PH_DATA: begin
            rx_shift <= {serial_in_pin, rx_shift[8:1]};  // R16
            rx_par   <= rx_par ^ serial_in_pin;
            rx_cnt   <= rx_cnt + 4'h1;
            if (rx_last) begin
              rx_ph <= parity_on ? PH_PARITY : PH_STOP1;
            end
          end
          PH_PARITY: begin
            parity_error <= (rx_par ^ parity_odd) != serial_in_pin;  // R20
            rx_ph        <= PH_STOP1;
          end
          default: begin
            // Only the first stop bit is checked
            frame_error_flag <= ~serial_in_pin;  // R19
            rx_buf           <= {rx_shift >> (4'h9 - nbits)};
            rx_complete_flag <= 1'b1;
            rx_ph            <= PH_IDLE;
          end
        endcase
        if (rx_ph != PH_PARITY && !parity_on) begin
          parity_error <= 1'b0;
        end
      end
      // Reading data clears, a new character wins
      if (rd_data && !(rx_smp && rx_ph == PH_STOP1)) begin
        rx_complete_flag <= 1'b0;
      end
    end
  end

  // Read mux
  wire [31:0] rd_value = hit_a    ? {24'h0, rx_complete_flag, tx_complete_flag, ~tx_buf_full, 3'h0,
                                     double_speed, 1'b0}
                       : hit_b    ? {24'h0, 3'h0, rx_enable, tx_enable, char_size_hi, rx_buf[8], tx_bit8}
                       : hit_c    ? {24'h0, ctrl_c}
                       : hit_lo   ? {24'h0, baud_divisor[7:0]}
                       : hit_hi   ? {28'h0, baud_divisor[11:8]}
                       : hit_data ? {24'h0, rx_buf[7:0]}
                       : hit_stat ? {28'h0, rx_ph != PH_IDLE, tx_ph != PH_IDLE, parity_error, frame_error_flag}
                       : 32'h0000_0000;

  // APB answer: no wait state, registered outputs
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else if (clk_en) begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped;
      if (apb_rd) begin
        prdata <= rd_value;
      end
    end
  end

  // Pin outputs: clock pin idle unless synchronous master
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      transfer_clock_out <= 1'b0;
      transfer_clock_oe  <= 1'b0;
      clock_mode         <= MODE_ASYNC_NORMAL;
    end else if (clk_en) begin
      transfer_clock_out <= is_master & master_clk;  // R25
      transfer_clock_oe  <= is_master;  // R03
      clock_mode         <= next_mode;  // R01
    end
  end
endmodule
`default_nettype wire

// File: design/usart_clk_map.svh
// Offsets, field positions, reset values and counts for the serial clock and frame block.
// Assumes a 32-bit APB slave with one aligned word per register.
`ifndef USART_CLK_MAP_SVH
`define USART_CLK_MAP_SVH

// Register byte addresses
`define OFS_CTRL_A        12'h000
`define OFS_CTRL_B        12'h004
`define OFS_CTRL_C        12'h008
`define OFS_DIV_LOW       12'h00C
`define OFS_DIV_HIGH      12'h010
`define OFS_DATA          12'h014
`define OFS_STATUS        12'h018

// Control A fields
`define A_DOUBLE_SPEED    1
`define A_TX_COMPLETE     6
`define A_RX_COMPLETE     7
// Control B fields
`define B_TX_BIT8         0
`define B_RX_BIT8         1
`define B_CHAR_SIZE_HI    2
`define B_RX_ENABLE       4
`define B_TX_ENABLE       3
// Control C fields
`define C_CLOCK_POLARITY  0
`define C_CHAR_SIZE_LO    1
`define C_STOP_BITS       3
`define C_PARITY_MODE     4
`define C_SYNC_MODE       6
`define C_CLOCK_DIR       7
// Status fields
`define S_FRAME_ERROR     0
`define S_PARITY_ERROR    1
`define S_TX_BUSY         2
`define S_RX_BUSY         3

// Reset values
`define RST_CTRL_C        8'h06
`define RST_DIVISOR       12'h000

// Sample counts per bit by mode, nine-bit size code and parity codes
`define STATES_NORMAL     5'd16
`define STATES_DOUBLE     5'd8
`define STATES_SYNC       5'd2
`define CHAR_SIZE_NINE    3'h7
`define PARITY_EVEN       2'h2
`define PARITY_ODD        2'h3

`endif

// File: design/usart_clk_pkg.sv
// Types shared by the serial clock and frame block.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package usart_clk_pkg;
  // Clocking modes
  typedef enum logic [1:0] {
    MODE_ASYNC_NORMAL = 2'b00,
    MODE_ASYNC_DOUBLE = 2'b01,
    MODE_SYNC_MASTER  = 2'b10,
    MODE_SYNC_SLAVE   = 2'b11
  } clk_mode_t;
  // Frame phases for transmitter and receiver
  typedef enum logic [2:0] {
    PH_IDLE   = 3'b000,
    PH_START  = 3'b001,
    PH_DATA   = 3'b010,
    PH_PARITY = 3'b011,
    PH_STOP1  = 3'b100,
    PH_STOP2  = 3'b101
  } phase_t;
endpackage
`default_nettype wire

// File: tb/usart_clk_chk_assertions.sv
// Port timing checks for the serial clock and frame block.
// Assumes it is bound onto usart_clk_frame.
`default_nettype none
module usart_clk_chk (
  input wire logic                      ref_clk,
  input wire logic                      arst_n,
  input wire logic                      clk_en,
  input wire logic                      psel,
  input wire logic                      penable,
  input wire logic                      pready,
  input wire logic                      pslverr,
  input wire logic                      serial_out_pin,
  input wire logic                      transfer_clock_out,
  input wire logic                      transfer_clock_oe,
  input wire usart_clk_pkg::clk_mode_t  clock_mode
);
  import usart_clk_pkg::*;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  // Bus answers the cycle after setup, for one cycle
  property p_ready; psel && !penable |=> pready; endproperty
  a_ready: assert property (p_ready) else $error("no answer after setup");
  property p_pulse; pready |=> !pready; endproperty
  a_pulse: assert property (p_pulse) else $error("answer longer than one cycle");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err) else $error("error without answer");
  // Pin driven only as master
  property p_oe; $stable(clock_mode) |-> transfer_clock_oe == (clock_mode == MODE_SYNC_MASTER); endproperty
  a_oe: assert property (p_oe) else $error("clock pin drive wrong for mode");
  property p_quiet; (!clock_mode[1]) [*3] |-> !transfer_clock_out && !transfer_clock_oe; endproperty
  a_quiet: assert property (p_quiet) else $error("clock pin active in async mode");
  property p_slave; (clock_mode == MODE_SYNC_SLAVE) [*2] |-> !transfer_clock_oe && !transfer_clock_out; endproperty
  a_slave: assert property (p_slave) else $error("slave drives clock pin");
  // Line idles high out of reset
  property p_idle; !$past(arst_n) |-> serial_out_pin && !pready; endproperty
  a_idle: assert property (p_idle) else $error("line not idle after reset");
  // Enable low freezes the pins
  property p_freeze; !$past(clk_en) |-> $stable(serial_out_pin) && $stable(transfer_clock_out); endproperty
  a_freeze: assert property (p_freeze) else $error("pins moved while frozen");
endmodule
bind usart_clk_frame usart_clk_chk i_chk (.ref_clk(ref_clk), .arst_n(arst_n), .clk_en(clk_en), .psel(psel),
  .penable(penable), .pready(pready), .pslverr(pslverr), .serial_out_pin(serial_out_pin),
  .transfer_clock_out(transfer_clock_out), .transfer_clock_oe(transfer_clock_oe), .clock_mode(clock_mode));
`default_nettype wire

// File: tb/serial_peer.sv
// Remote serial transceiver on the data lines.
// Assumes the bench sets bit and frame length before each frame.
`default_nettype none
module serial_peer (
  input  wire logic        ref_clk,
  input  wire logic        serial_out_pin,
  input  wire logic [15:0] bit_clks,
  input  wire logic [3:0]  n_bits,
  output logic             serial_in_pin,
  output logic             got,
  output logic      [12:0] frame
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [12:0] f;  // Bits gathered so far
  initial begin
    serial_in_pin = 1'b1;
    got = 1'b0;
    frame = 13'h0000;
  end
  // Catch a frame mid-bit, first bit at bit 0
  always begin
    @(negedge serial_out_pin);
    f = 13'h0000;
    repeat (bit_clks / 2) @(posedge ref_clk);
    for (int i = 0; i < n_bits; i++) begin
      f[i] = serial_out_pin;
      if (i < n_bits - 1) repeat (bit_clks) @(posedge ref_clk);
    end
    frame <= f;
    got <= 1'b1;
    @(posedge ref_clk);
    got <= 1'b0;
  end
  // Send bits first to last, then idle high
  task automatic send(input logic [12:0] b, input int n);
    for (int i = 0; i < n; i++) begin
      serial_in_pin <= b[i];
      repeat (bit_clks) @(posedge ref_clk);
    end
    serial_in_pin <= 1'b1;
  endtask
endmodule
`default_nettype wire

// File: tb/tb_usart_clock_and_frame_format.sv
// Self-checking bench for the serial clock and frame block.
// Assumes package, header, design, checker and peer compile first.
`default_nettype none
`include "usart_clk_map.svh"
module tb_usart_clock_and_frame_format;
  timeunit 1ns;
  timeprecision 1ns;
  import usart_clk_pkg::*;
  logic        ref_clk = 1'b0, arst_n = 1'b0, clk_en = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;  // Bus data, last read
  logic        pready, pslverr, sin, sout, tco, tcoe, got, tb8, xin = 1'b0;
  logic [15:0] bit_clks = 16'h0010;  // Clocks per bit
  logic [3:0]  n_bits = 4'hA;  // Bits per frame
  logic [12:0] frame, w, f;
  logic [2:0]  cs;
  logic [1:0]  par;
  logic [7:0]  d;
  logic [64:0] ex;
  clk_mode_t   clock_mode;
  logic [64:0] q_apb[$];  // Mask, data, error
  logic [12:0] q_ser[$];  // Expected frames
  int          fails = 0, n_tests = 0, div, k, nd;
  time         t0;
  usart_clk_frame i_dut (.ref_clk(ref_clk), .arst_n(arst_n), .clk_en(clk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .serial_in_pin(sin), .serial_out_pin(sout), .transfer_clock_in(xin), .transfer_clock_out(tco),
    .transfer_clock_oe(tcoe), .clock_mode(clock_mode));
  serial_peer i_peer (.ref_clk(ref_clk), .serial_out_pin(sout), .bit_clks(bit_clks), .n_bits(n_bits),
    .serial_in_pin(sin), .got(got), .frame(frame));
  always #25 ref_clk = ~ref_clk;
  task automatic check(input logic [31:0] g, x);
    n_tests++;
    if (g !== x) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, g, x);
    end
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // One bus transfer, entered just after an edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] dat, m, e, input logic err);
    q_apb.push_back({m, e, err});
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= dat;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask
  // Compare each answer with the oldest note
  always @(posedge ref_clk) begin
    if (pready) begin
      ex = q_apb.pop_front();
      check({31'h0, pslverr}, {31'h0, ex[0]});
      if (ex[64:33] != 0) check(prdata & ex[64:33], ex[32:1]);
    end
    if (got && q_ser.size() > 0) check({19'h0, frame}, {19'h0, q_ser.pop_front()});
  end
  initial begin
    void'($urandom(15777));
    repeat (20) @(posedge ref_clk);
    arst_n <= 1'b1;
    @(posedge ref_clk);
    apb(0, `OFS_CTRL_C, 0, 32'hFF, `RST_CTRL_C, 0);
    apb(0, 12'hFFC, 0, 32'hFFFFFFFF, 0, 1);
    apb(1, 12'hFF0, 32'h5A, 0, 0, 1);
    apb(1, `OFS_DIV_HIGH, 32'hF, 0, 0, 0);
    apb(1, `OFS_DIV_LOW, 32'hFF, 0, 0, 0);
    apb(0, `OFS_DIV_HIGH, 0, 32'hFF, 32'hF, 0);
    apb(0, `OFS_DIV_LOW, 0, 32'hFF, 32'hFF, 0);
    apb(1, `OFS_DIV_HIGH, 0, 0, 0, 0);
    clk_en <= 1'b0;
    repeat (4) @(posedge ref_clk);
    clk_en <= 1'b1;
    // All thirty formats in both async modes, two frames each
    for (int md = 0; md < 2; md++) begin
      for (int c = 0; c < 30; c++) begin
        cs = (c % 5 == 4) ? 3'h7 : 3'(c % 5);
        par = (c / 5 % 3 == 0) ? 2'h0 : 2'(c / 5 % 3 + 1);
        div = $urandom % 3;
        nd = (cs == 3'h7) ? 9 : cs + 5;
        bit_clks <= 16'((div + 1) * (md ? 8 : 16));
        n_bits <= 4'(nd + (par[1] ? 3 : 2) + c / 15);
        apb(1, `OFS_DIV_LOW, div, 0, 0, 0);
        apb(1, `OFS_CTRL_A, md << `A_DOUBLE_SPEED, 0, 0, 0);
        apb(1, `OFS_CTRL_C, {par, 1'(c / 15), cs[1:0], 1'b0}, 0, 0, 0);
        for (int j = 0; j < 2; j++) begin
          d = 8'($urandom);
          tb8 = 1'($urandom);
          w = {tb8, d} & ((13'h1 << nd) - 13'h1);
          f = w << 1;
          k = nd + 1;
          if (par[1]) begin
            f[k] = ^w ^ par[0];
            k++;
          end
          f = f | (13'h3 << k);
          rd = 32'h0;
          while (!rd[5]) apb(0, `OFS_CTRL_A, 0, 0, 0, 0);
          apb(1, `OFS_CTRL_B, {27'h0, 2'b11, cs[2], 1'b0, tb8}, 0, 0, 0);
          q_ser.push_back(f & ((13'h1 << n_bits) - 13'h1));
          apb(1, `OFS_DATA, {24'h0, d}, 0, 0, 0);
        end
        check({30'h0, clock_mode}, md);
        while (q_ser.size() > 0) @(posedge ref_clk);
        rd = 32'h4;
        while (rd[`S_TX_BUSY]) apb(0, `OFS_STATUS, 0, 0, 0, 0);
      end
    end
    // Received frames: good, bad parity, bad first stop, bad second stop
    bit_clks <= 16'h0010;
    apb(1, `OFS_DIV_LOW, 0, 0, 0, 0);
    apb(1, `OFS_CTRL_A, 0, 0, 0, 0);
    apb(1, `OFS_CTRL_B, 32'h18, 0, 0, 0);
    apb(1, `OFS_CTRL_C, 32'h2E, 0, 0, 0);
    for (int c = 0; c < 4; c++) begin
      d = 8'($urandom);
      i_peer.send({c != 3, c != 2, ^d ^ (c == 1), d, 1'b0}, 12);
      apb(0, `OFS_STATUS, 0, 32'h3, {c == 1, c == 2}, 0);
      apb(0, `OFS_DATA, 0, 32'hFF, d, 0);
    end
    // Master with double speed left on, then slave
    apb(1, `OFS_DIV_LOW, 1, 0, 0, 0);
    apb(1, `OFS_CTRL_A, 32'h2, 0, 0, 0);
    apb(1, `OFS_CTRL_C, 32'hC6, 0, 0, 0);
    apb(1, `OFS_DATA, 32'hA5, 0, 0, 0);
    check({31'h0, tcoe}, 1);
    check({30'h0, clock_mode}, MODE_SYNC_MASTER);
    @(posedge tco);
    t0 = $time;
    @(posedge tco);
    check(32'(($time - t0) / 50), 4);
    repeat (60) @(posedge ref_clk);
    apb(1, `OFS_CTRL_C, 32'h46, 0, 0, 0);
    apb(1, `OFS_CTRL_A, 0, 0, 0, 0);
    check({31'h0, tcoe}, 0);
    check({30'h0, clock_mode}, MODE_SYNC_SLAVE);
    apb(1, `OFS_DATA, 32'h3C, 0, 0, 0);
    repeat (20) @(posedge ref_clk);
    check({31'h0, sout}, 1);
    xin <= 1'b1;
    repeat (4) @(posedge ref_clk);
    check({31'h0, sout}, 0);
    end_of_test();
  end
  // Cut a hang short
  initial begin
    repeat (100000) @(posedge ref_clk);
    fails++;
    end_of_test();
  end
endmodule
`default_nettype wire
